// ---- design/stt_map.svh ----
// Constants for the system tick down-counter: offsets, fields, reset values, counts.
// Assumes inclusion by bare name from the package and the design module.
// Operation
// - Reload holds 24 bits; upper byte reads zero.
// - At zero, counter reloads and keeps counting.
// - Control bit 0 enables; setting loads, starts.
// - Control bit 1 enables zero-event exception request.
// - Control bit 2: 0 reference, 1 CPU clock.
// - Bit 16 shows zero reached since read.
// - Any control register read clears the flag.
// - Reference clock is crystal input divided by 32.
// - Registers decoded at 0x10, 0x14, 0x18, 0x1C, 0x20, 0x24.
// - Offsets relative to private peripheral base address.
// - Current-value write clears counter and flag.
// - Calibration reports 10 ms reload value 0x9C4.
`ifndef STT_MAP_SVH
`define STT_MAP_SVH

// ----------------------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------------------
`define STT_BASE_ADDR 32'hE000_E000
`define STT_OFF_CTRL 12'h010
`define STT_OFF_RELOAD 12'h014
`define STT_OFF_CURRENT 12'h018
`define STT_OFF_CALIB 12'h01C
`define STT_OFF_IRQ_STATUS 12'h020
`define STT_OFF_IRQ_MASK 12'h024

// ----------------------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------------------
`define STT_CTRL_ENABLE_BIT 0
`define STT_CTRL_REQ_EN_BIT 1
`define STT_CTRL_CLKSEL_BIT 2
`define STT_CTRL_FLAG_BIT 16
`define STT_CALIB_TEN_MS 24'h00_09C4
`define STT_CTRL_RESET 32'h0000_0000
`define STT_REF_DIVIDE 32
`define STT_CLK_HZ 25000000

`endif

// ---- design/stt_pkg.sv ----
// Types for the system tick down-counter.
// Assumes the constants header sits beside it.
`include "stt_map.svh"

package stt_pkg;
  typedef logic [23:0] stt_count_t;
  typedef logic [1:0] stt_resp_t;
  localparam stt_resp_t STT_RESP_OKAY = 2'h0;
  localparam stt_resp_t STT_RESP_SLVERR = 2'h2;
endpackage

// ---- design/stt_timer.sv ----
// System tick down-counter with an AXI4-Lite register slave.
// Assumes a single 25 MHz clock; the crystal input is sampled synchronously to it.
`timescale 1ns/1ps
`default_nettype none
`include "stt_map.svh"

module stt_timer #(
  parameter int unsigned REF_DIVIDE = `STT_REF_DIVIDE,
  parameter logic [23:0] TEN_MS = `STT_CALIB_TEN_MS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output stt_pkg::stt_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output stt_pkg::stt_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Crystal input and tick outputs
  input wire logic crystal_input,
  output logic tick_exception_req,
  output logic irq
);
  import stt_pkg::*;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic logic [2:0] stt_decode(input logic [31:0] addr);
    logic [2:0] sel;
    sel = 3'h7;
    if (addr[31:12] == `STT_BASE_ADDR >> 12 && addr[1:0] == 2'h0) begin
      unique case (addr[11:0])
        `STT_OFF_CTRL: sel = 3'h0;
        `STT_OFF_RELOAD: sel = 3'h1;
        `STT_OFF_CURRENT: sel = 3'h2;
        `STT_OFF_CALIB: sel = 3'h3;
        `STT_OFF_IRQ_STATUS: sel = 3'h4;
        `STT_OFF_IRQ_MASK: sel = 3'h5;
        default: sel = 3'h7;
      endcase
    end
    return sel;
  endfunction

  // The control word is built once here, so a read and a byte-merged write see the same layout.
  function automatic logic [31:0] stt_ctrl_word(input logic flag, input logic clk_sel, input logic req_en,
                                                input logic en);
    logic [31:0] word;
    word = {15'h0000, flag, 13'h0000, clk_sel, req_en, en};
    return word;
  endfunction

  function automatic logic [31:0] stt_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // --------------------------------------------------------------------------
  // Bus state
  // --------------------------------------------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  logic rd_fire;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;

  logic enable_reg;
  logic req_en_reg;
  logic clk_sel_reg;
  logic flag_reg;
  stt_count_t reload_reg;
  stt_count_t current_reg;
  logic irq_status_reg;
  logic irq_mask_reg;
  logic [4:0] div_reg;
  logic xtal_prev_reg;
  logic ref_tick;
  logic count_tick;
  logic zero_event;
  logic start_load;
  logic current_clear;
  logic [31:0] ctrl_wval;

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_sel = stt_decode(awaddr_reg);
  assign rd_sel = stt_decode(s_axi_araddr);
  assign ctrl_wval = stt_merge(stt_ctrl_word(flag_reg, clk_sel_reg, req_en_reg, enable_reg),
                               wdata_reg, wstrb_reg);

  // --------------------------------------------------------------------------
  // Write channels
  // --------------------------------------------------------------------------
  // Ready is a one-cycle pulse; no new address is taken while a response waits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_reg && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
    end
  end

  // Address and data are held separately, so the master may offer them in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 32'h0000_0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= STT_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_sel == 3'h7 || wr_sel == 3'h3) ? STT_RESP_SLVERR : STT_RESP_OKAY;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Read channels
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= STT_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= STT_RESP_OKAY;
        unique case (rd_sel)
          3'h0: s_axi_rdata <= stt_ctrl_word(flag_reg, clk_sel_reg, req_en_reg, enable_reg);
          3'h1: s_axi_rdata <= {8'h00, reload_reg};
          3'h2: s_axi_rdata <= {8'h00, current_reg};
          3'h3: s_axi_rdata <= {8'h00, TEN_MS};
          3'h4: s_axi_rdata <= {31'h0000_0000, irq_status_reg};
          3'h5: s_axi_rdata <= {31'h0000_0000, irq_mask_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= STT_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Control and reload registers
  // --------------------------------------------------------------------------
  assign start_load = wr_fire && wr_sel == 3'h0 && ctrl_wval[`STT_CTRL_ENABLE_BIT] && !enable_reg;
  assign current_clear = wr_fire && wr_sel == 3'h2;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg <= 1'b0;
      req_en_reg <= 1'b0;
      clk_sel_reg <= 1'b0;
    end else if (wr_fire && wr_sel == 3'h0) begin
      enable_reg <= ctrl_wval[`STT_CTRL_ENABLE_BIT];
      req_en_reg <= ctrl_wval[`STT_CTRL_REQ_EN_BIT];
      clk_sel_reg <= ctrl_wval[`STT_CTRL_CLKSEL_BIT];
    end
  end

  // Only the low 24 bits are stored, so the upper byte always reads back as zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_reg <= 24'h00_0000;
    end else if (wr_fire && wr_sel == 3'h1) begin
      reload_reg <= stt_merge({8'h00, reload_reg}, wdata_reg, wstrb_reg)[23:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_reg <= 1'b0;
    end else if (wr_fire && wr_sel == 3'h5 && wstrb_reg[0]) begin
      irq_mask_reg <= wdata_reg[0];
    end
  end

  // --------------------------------------------------------------------------
  // Reference clock divider
  // --------------------------------------------------------------------------
  // Rising edges of the crystal input are counted; it must run below half of aclk.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xtal_prev_reg <= 1'b0;
      div_reg <= 5'h00;
    end else begin
      xtal_prev_reg <= crystal_input;
      if (crystal_input && !xtal_prev_reg) begin
        div_reg <= (div_reg == 5'(REF_DIVIDE - 1)) ? 5'h00 : div_reg + 5'h01;
      end
    end
  end
  assign ref_tick = crystal_input && !xtal_prev_reg && div_reg == 5'(REF_DIVIDE - 1);
  assign count_tick = clk_sel_reg ? 1'b1 : ref_tick;

  // --------------------------------------------------------------------------
  // Down-counter
  // --------------------------------------------------------------------------
  assign zero_event = enable_reg && count_tick && current_reg == 24'h00_0001;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_reg <= 24'h00_0000;
    end else if (current_clear) begin
      current_reg <= 24'h00_0000;
    end else if (start_load) begin
      current_reg <= reload_reg;
    end else if (enable_reg && count_tick) begin
      if (current_reg == 24'h00_0000) begin
        current_reg <= reload_reg;
      end else begin
        current_reg <= current_reg - 24'h00_0001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Zero flag, exception request and interrupt
  // --------------------------------------------------------------------------
  // A zero event in the clearing cycle wins, so no event is lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= 1'b0;
    end else if (zero_event) begin
      flag_reg <= 1'b1;
    end else if ((rd_fire && rd_sel == 3'h0) || current_clear) begin
      flag_reg <= 1'b0;
    end
  end

  // The status bit is sticky and cleared by writing a one to it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= 1'b0;
    end else if (zero_event) begin
      irq_status_reg <= 1'b1;
    end else if (wr_fire && wr_sel == 3'h4 && wstrb_reg[0] && wdata_reg[0]) begin
      irq_status_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_exception_req <= 1'b0;
    end else begin
      tick_exception_req <= zero_event && req_en_reg;
    end
  end

  // The event term lets the interrupt rise in the same cycle as the status bit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (irq_status_reg || zero_event) && irq_mask_reg;
    end
  end

endmodule
`default_nettype wire

// ---- testbench/stt_timer_properties.sv ----
// Concurrent checks on the tick timer's bus and tick ports.
// Assumes it is bound to stt_timer; it sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "stt_map.svh"
module stt_props #(
  parameter int unsigned REF_DIVIDE = `STT_REF_DIVIDE,
  parameter logic [23:0] TEN_MS = `STT_CALIB_TEN_MS
) (
  // Watched ports
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire stt_pkg::stt_resp_t s_axi_bresp,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic tick_exception_req
);
  import stt_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic cal_rd;
  // The response of a read refers back to the address taken before it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_rd <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      cal_rd <= (s_axi_araddr == `STT_BASE_ADDR + `STT_OFF_CALIB);
    end
  end
  sequence aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  aw_cause_a: assert property (s_axi_awready |-> s_axi_awvalid) else $error("awready without awvalid");
  ar_cause_a: assert property (s_axi_arready |-> s_axi_arvalid) else $error("arready without arvalid");
  b_follow_a: assert property (aw_taken |-> ##[1:3] s_axi_bvalid) else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_follow_a: assert property (ar_taken |=> s_axi_rvalid) else $error("read data late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  calib_value_a: assert property (s_axi_rvalid && cal_rd |-> s_axi_rdata == {8'h00, TEN_MS})
    else $error("calibration value wrong");
  tick_pulse_a: assert property (tick_exception_req |=> !tick_exception_req) else $error("request too long");
endmodule
bind stt_timer stt_props #(.REF_DIVIDE(REF_DIVIDE), .TEN_MS(TEN_MS)) u_stt_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .tick_exception_req(tick_exception_req));
`default_nettype wire

// ---- testbench/stt_timer_bench.sv ----
// Self-checking bench for the tick timer.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "stt_map.svh"
module stt_timer_bench;
  import stt_pkg::*;
  // ----------------------------------------------------------------------
  // Stimulus and checks
  // ----------------------------------------------------------------------
  localparam int REF = 4;
  localparam logic [31:0] CT = 32'h0000_0010, RL = 32'h0000_0014, CU = 32'h0000_0018;
  localparam logic [31:0] CA = 32'h0000_001C, ST = 32'h0000_0020, MK = 32'h0000_0024;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, xtal = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, got, v;
  logic awready, wready, bvalid, arready, rvalid, req, irq;
  logic [1:0] xc = 0;
  stt_resp_t bresp, rresp, rsp;
  logic [31:0] offs [6] = '{CT, RL, CU, CA, ST, MK};
  logic [31:0] rexp [6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_09C4, 32'h0000_0000, 32'h0000_0000};
  int n_mismatch = 0, checks_done = 0, n_pulse = 0, t, n;
  stt_timer #(.REF_DIVIDE(REF)) u_stt_timer (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .crystal_input(xtal), .tick_exception_req(req), .irq(irq));
  always #20 aclk = ~aclk;
  // The crystal toggles every third cycle, well below half the bus clock.
  always @(posedge aclk) begin
    xc <= (xc == 2'h2) ? 2'h0 : xc + 2'h1;
    if (xc == 2'h2) xtal <= ~xtal;
    if (req) n_pulse++;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic to_fail;
    n_mismatch++;
    final_report();
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= `STT_BASE_ADDR + a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awv <= 0;
      if (wready) wv <= 0;
      if (bvalid) begin
        rsp = bresp;
        bready <= 0;
        return;
      end
    end
    to_fail();
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    araddr <= `STT_BASE_ADDR + a;
    arv <= 1;
    rready <= 1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arv <= 0;
      if (rvalid) begin
        got = rdata;
        rsp = rresp;
        rready <= 0;
        return;
      end
    end
    to_fail();
  endtask
  // Cycles from one exception request to the next.
  task automatic period(output int p);
    p = 0;
    for (int i = 0; i < 4000; i++) begin
      @(posedge aclk);
      if (req && p > 0) return;
      if (req || p > 0) p++;
    end
    to_fail();
  endtask
  initial begin
    void'($urandom(94520));
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    foreach (offs[k]) begin
      rd(offs[k]);
      chk("reset value", rexp[k], got);
    end
    rd(32'h0000_0030);
    chk("unmapped resp", {30'h0, STT_RESP_SLVERR}, {30'h0, rsp});
    wr(CA, $urandom);
    chk("calib write resp", {30'h0, STT_RESP_SLVERR}, {30'h0, rsp});
    repeat (3) begin
      v = $urandom;
      wr(RL, v);
      rd(RL);
      chk("reload", v & 32'h00FF_FFFF, got);
    end
    n = 2 + $urandom_range(6);
    wr(RL, n);
    wr(CT, 32'h0000_0007);
    period(t);
    chk("cpu period", n + 1, t);
    wr(CT, 32'h0000_0003);
    period(t);
    period(t);
    chk("ref period", (n + 1) * REF * 6, t);
    wr(CT, 32'h0000_0000);
    rd(CT);
    chk("flag set", 32'h0001_0004 & 32'h0001_0000, got);
    rd(CT);
    chk("flag cleared", 32'h0000_0000, got);
    wr(CT, 32'h0000_0005);
    n_pulse = 0;
    repeat (3 * (n + 1)) @(posedge aclk);
    chk("masked request", 0, n_pulse);
    wr(CT, 32'h0000_0000);
    wr(CU, $urandom);
    rd(CT);
    chk("flag after clear", 32'h0000_0000, got);
    repeat (5) @(posedge aclk);
    rd(CU);
    chk("current cleared", 32'h0000_0000, got);
    rd(ST);
    chk("irq status", 32'h0000_0001, got);
    chk("irq masked", 0, {31'h0, irq});
    wr(MK, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk("irq raised", 1, {31'h0, irq});
    wr(ST, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 0, {31'h0, irq});
    final_report();
  end
endmodule
`default_nettype wire
